// [core/spin_consts.vh]
// Register map, field positions and link framing constants
`ifndef SPIN_CONSTS_VH
`define SPIN_CONSTS_VH
`define SPIN_OFF_CTRL       4'h0
`define SPIN_OFF_STATUS     4'h4
`define SPIN_OFF_WORDCNT    4'h8
`define SPIN_OFF_ERRCNT     4'hc
`define SPIN_CTRL_TXEN      0
`define SPIN_CTRL_USEREG    1
`define SPIN_CTRL_EDGE      2
`define SPIN_CTRL_CFG_LO    3
`define SPIN_CTRL_CFG_HI    4
`define SPIN_CTRL_SELFTEST  5
`define SPIN_CTRL_RESET     6'h01
`define SPIN_ST_OVERRUN     0
`define SPIN_ST_STACTIVE    1
`define SPIN_ST_STPASS      2
`define SPIN_CFG_FILT_OFF   2'h0
`define SPIN_CFG_FILT_ON    2'h1
`define SPIN_FILT_STABLE    2'h3
`define SPIN_WORD_BITS      27
`define SPIN_FRAME_LAST     5'h1d
`define SPIN_HALF_WORD      5'h0d
`define SPIN_LFSR_SEED      16'hace1
`define SPIN_ST_SEED        16'h5a5a
`define SPIN_ST_SETTLE      2'h3
`endif

// [core/spin_link_serializer.v]
// Scrambler, DC-balance encoder and embedded-clock serializer
`timescale 1ns/100ps
`include "spin_consts.vh"
module spin_link_serializer (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        clkEn,
  input  wire        powerDown,
  input  wire        loadValid,
  input  wire [26:0] loadWord,
  input  wire        scrambleOn,
  output wire        loadReady,
  output reg         serOutP_r,
  output reg         serOutN_r
);
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;

  reg  [1:0]  state_r;
  reg  [4:0]  bitCnt_r;
  reg  [29:0] frame_r;
  reg  [15:0] lfsr_r;
  reg  [7:0]  runDisp_r;
  reg         idleBit_r;
  reg  [26:0] scrWord;
  reg  [4:0]  ones;
  reg         invert;
  reg  [4:0]  onesEff;
  reg  [7:0]  disp_nxt;
  integer     i;

  wire [15:0] lfsr_nxt = {lfsr_r[14:0],
                          lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};

  assign loadReady = (state_r == ST_IDLE) && !powerDown;

  always @* begin
    scrWord = scrambleOn ? (loadWord ^ {lfsr_r[10:0], lfsr_r}) : loadWord;
    ones = 5'h00;
    for (i = 0; i < `SPIN_WORD_BITS; i = i + 1) begin
      ones = ones + {4'h0, scrWord[i]};
    end
    // Invert when the word would push running disparity further away
    invert = (!runDisp_r[7] && (runDisp_r != 8'h00) &&
              (ones > `SPIN_HALF_WORD)) ||
             (runDisp_r[7] && !(ones > `SPIN_HALF_WORD));
    onesEff = invert ? (5'h1b - ones) : ones;
    disp_nxt = runDisp_r + {2'h0, onesEff, 1'b0} - 8'h1b +
               (invert ? 8'h01 : 8'hff);
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      bitCnt_r  <= 5'h00;
      frame_r   <= 30'h00000000;
      lfsr_r    <= `SPIN_LFSR_SEED;
      runDisp_r <= 8'h00;
      idleBit_r <= 1'b0;
      serOutP_r <= 1'b1;
      serOutN_r <= 1'b1;
    end else if (clkEn) begin
      if (powerDown) begin
        state_r   <= ST_IDLE;
        lfsr_r    <= `SPIN_LFSR_SEED;
        runDisp_r <= 8'h00;
        serOutP_r <= 1'b1;
        serOutN_r <= 1'b1;
      end else begin
        case (state_r)
          ST_IDLE: begin
            // Idle clock pattern keeps the far end locked between words
            idleBit_r <= ~idleBit_r;
            serOutP_r <= idleBit_r;
            serOutN_r <= ~idleBit_r;
            if (loadValid) begin
              // Clock edge embedded as a 1 start and 0 stop bit
              frame_r   <= {1'b1, invert ? ~scrWord : scrWord, invert, 1'b0};
              lfsr_r    <= lfsr_nxt;
              runDisp_r <= disp_nxt;
              bitCnt_r  <= `SPIN_FRAME_LAST;
              state_r   <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            serOutP_r <= frame_r[29];
            serOutN_r <= ~frame_r[29];
            frame_r   <= {frame_r[28:0], 1'b0};
            bitCnt_r  <= bitCnt_r - 5'h01;
            if (bitCnt_r == 5'h00) begin
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // spin_link_serializer

// [core/spin_parallel_input.v]
// Parallel pixel input stage of the serializer with Avalon-MM registers
//
// Overview of operation
// - One 24-bit word plus three controls per clock
// - Filter on: data-enable and line sync pass only pulses of three or more clocks
// - Filter off: forward control changes unrestricted
// - Capture on the edge that select designates
// - Serial stream with embedded clock, no clock line
// - Scramble (config 00/01 only) and DC-balance the outgoing words
// - At-speed self-test checks link and reports integrity
// - Select high rising edge, low falling edge
// - Config: 00 off, 01 filter, 10/11 compatibility
// - Power-down: serial outputs high, registers except ERRCNT back to reset
// - Self-test enable low normal, high test
`timescale 1ns/100ps
`include "spin_consts.vh"
module spin_parallel_input (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        clkEn,
  input  wire        parallelClockIn,
  input  wire [23:0] pixelWordIn,
  input  wire        dataValidCtrl,
  input  wire        lineSyncCtrl,
  input  wire        frameSyncCtrl,
  input  wire        strobeEdgeSelect,
  input  wire [1:0]  configSelect,
  input  wire        powerDownN,
  input  wire        selfTestEnable,
  input  wire        linkReturn,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output wire        currentModeSerialP,
  output wire        currentModeSerialN,
  output reg         selfTestPass_r
);
  // Pin synchronisers; first stages are read only by second stages
  reg  [26:0] pinS1_r;
  reg  [26:0] pinS2_r;
  reg  [4:0]  cfgS1_r;
  reg  [4:0]  cfgS2_r;
  reg         pclkS1_r;
  reg         pclkS2_r;
  reg         pclkS3_r;
  reg         lnkS1_r;
  reg         lnkS2_r;

  reg  [5:0]  ctrl_r;
  reg         overrun_r;
  reg  [15:0] wordCnt_r;
  reg  [15:0] errCnt_r;
  reg  [26:0] capWord_r;
  reg         capValid_r;
  wire [1:0]  filtLevel;
  reg  [15:0] stLfsr_r;
  reg         stActive_r;
  reg  [1:0]  stSettle_r;
  reg         txD1_r;
  reg         txD2_r;
  reg  [31:0] rdData;

  wire        pinPowerDownN = cfgS2_r[0];
  wire        powerDown = ~pinPowerDownN;
  wire        useReg = ctrl_r[`SPIN_CTRL_USEREG];
  wire        edgeSel = useReg ? ctrl_r[`SPIN_CTRL_EDGE] : cfgS2_r[1];
  wire [1:0]  cfgSel = useReg ?
                       ctrl_r[`SPIN_CTRL_CFG_HI:`SPIN_CTRL_CFG_LO] :
                       cfgS2_r[3:2];
  wire        selfTest = useReg ? ctrl_r[`SPIN_CTRL_SELFTEST] :
                         cfgS2_r[4];
  wire        filterOn = (cfgSel == `SPIN_CFG_FILT_ON);
  // Older deserializer families expect an unscrambled stream
  wire        scrambleOn = ~cfgSel[1];
  wire        riseEdge = pclkS2_r & ~pclkS3_r;
  wire        fallEdge = ~pclkS2_r & pclkS3_r;
  wire        capEdge = edgeSel ? riseEdge : fallEdge;
  wire        txEnable = ctrl_r[`SPIN_CTRL_TXEN];
  wire        loadReady;
  wire        serLoad = loadReady && txEnable &&
                        (selfTest ? 1'b1 : capValid_r);
  wire [26:0] serWord = selfTest ? {stLfsr_r[10:0], stLfsr_r} :
                        capWord_r;
  wire [15:0] stLfsr_nxt = {stLfsr_r[14:0],
                            stLfsr_r[15] ^ stLfsr_r[13] ^
                            stLfsr_r[12] ^ stLfsr_r[10]};
  wire        busReq = avs_read | avs_write;
  wire        busTake = busReq & ~avs_waitrequest;
  wire        aligned = (avs_address[1:0] == 2'h0);
  wire        ctrlHit = aligned && (avs_address == `SPIN_OFF_CTRL);
  wire        statusHit = aligned && (avs_address == `SPIN_OFF_STATUS);
  wire        ovrClear = busTake && avs_write && statusHit &&
                         avs_byteenable[0] &&
                         avs_writedata[`SPIN_ST_OVERRUN];

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinS1_r  <= 27'h0000000;
      pinS2_r  <= 27'h0000000;
      cfgS1_r  <= 5'h00;
      cfgS2_r  <= 5'h00;
      pclkS1_r <= 1'b0;
      pclkS2_r <= 1'b0;
      pclkS3_r <= 1'b0;
      lnkS1_r  <= 1'b0;
      lnkS2_r  <= 1'b0;
    end else if (clkEn) begin
      pinS1_r  <= {frameSyncCtrl, lineSyncCtrl, dataValidCtrl,
                   pixelWordIn};
      pinS2_r  <= pinS1_r;
      cfgS1_r  <= {selfTestEnable, configSelect, strobeEdgeSelect,
                   powerDownN};
      cfgS2_r  <= cfgS1_r;
      pclkS1_r <= parallelClockIn;
      pclkS2_r <= pclkS1_r;
      pclkS3_r <= pclkS2_r;
      lnkS1_r  <= linkReturn;
      lnkS2_r  <= lnkS1_r;
    end
  end

  // Control filter for data-enable and line sync
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gFilt
      // Per-channel state keeps one process per register
      reg  [1:0] cnt_r;
      reg        cand_r;
      reg        level_r;
      wire       sample = pinS2_r[24 + g];
      wire       same = (sample == cand_r);
      wire [1:0] cnt_nxt = !same ? 2'h1 :
                           (cnt_r == `SPIN_FILT_STABLE) ?
                           cnt_r : (cnt_r + 2'h1);
      assign filtLevel[g] = level_r;
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          cnt_r   <= 2'h0;
          cand_r  <= 1'b0;
          level_r <= 1'b0;
        end else if (clkEn) begin
          if (powerDown) begin
            cnt_r   <= 2'h0;
            cand_r  <= 1'b0;
            level_r <= 1'b0;
          end else if (capEdge) begin
            cand_r <= sample;
            cnt_r  <= cnt_nxt;
            if (!filterOn) begin
              level_r <= sample;
            end else if (cnt_nxt == `SPIN_FILT_STABLE) begin
              level_r <= sample;
            end
          end
        end
      end
    end
  endgenerate

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r     <= `SPIN_CTRL_RESET;
      overrun_r  <= 1'b0;
      wordCnt_r  <= 16'h0000;
      capWord_r  <= 27'h0000000;
      capValid_r <= 1'b0;
    end else if (clkEn) begin
      if (powerDown) begin
        ctrl_r     <= `SPIN_CTRL_RESET;
        overrun_r  <= 1'b0;
        wordCnt_r  <= 16'h0000;
        capValid_r <= 1'b0;
      end else begin
        if (busTake && avs_write && ctrlHit && avs_byteenable[0]) begin
          ctrl_r <= avs_writedata[5:0];
        end
        if (capEdge) begin
          // Filtered levels lag the raw pins by the filter latency
          capWord_r  <= {pinS2_r[26],
                         filterOn ? filtLevel : pinS2_r[25:24],
                         pinS2_r[23:0]};
          capValid_r <= 1'b1;
          wordCnt_r  <= wordCnt_r + 16'h0001;
        end else if (serLoad && !selfTest) begin
          capValid_r <= 1'b0;
        end
        // No buffering: a word not yet sent is overwritten
        if (capEdge && capValid_r && !(serLoad && !selfTest)) begin
          overrun_r <= 1'b1;
        end else if (ovrClear) begin
          overrun_r <= 1'b0;
        end
      end
    end
  end

  // Self-test pattern source and loopback checker
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stLfsr_r       <= `SPIN_ST_SEED;
      stActive_r     <= 1'b0;
      stSettle_r     <= 2'h0;
      errCnt_r       <= 16'h0000;
      txD1_r         <= 1'b0;
      txD2_r         <= 1'b0;
      selfTestPass_r <= 1'b0;
    end else if (clkEn) begin
      txD1_r     <= currentModeSerialP;
      txD2_r     <= txD1_r;
      stActive_r <= selfTest & ~powerDown;
      if (!selfTest || powerDown) begin
        stSettle_r     <= 2'h0;
        selfTestPass_r <= 1'b0;
        stLfsr_r       <= `SPIN_ST_SEED;
      end else begin
        if (!stActive_r) begin
          errCnt_r <= 16'h0000;
        end else if (stSettle_r != `SPIN_ST_SETTLE) begin
          stSettle_r <= stSettle_r + 2'h1;
        end else if ((lnkS2_r != txD2_r) && (errCnt_r != 16'hffff)) begin
          errCnt_r <= errCnt_r + 16'h0001;
        end
        if (serLoad) begin
          stLfsr_r <= stLfsr_nxt;
        end
        selfTestPass_r <= (stSettle_r == `SPIN_ST_SETTLE) &&
                          (errCnt_r == 16'h0000);
      end
    end
  end

  always @* begin
    rdData = 32'h00000000;
    if (aligned) begin
      case (avs_address)
        `SPIN_OFF_CTRL:    rdData = {26'h0000000, ctrl_r};
        `SPIN_OFF_STATUS:  rdData = {29'h00000000, selfTestPass_r,
                                     stActive_r, overrun_r};
        `SPIN_OFF_WORDCNT: rdData = {16'h0000, wordCnt_r};
        `SPIN_OFF_ERRCNT:  rdData = {16'h0000, errCnt_r};
        default:           rdData = 32'h00000000;
      endcase
    end
  end

  // One wait cycle per access, then release for one cycle
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (clkEn) begin
      if (busReq && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= avs_read ? rdData : 32'h00000000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  spin_link_serializer uSer (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .clkEn      (clkEn),
    .powerDown  (powerDown),
    .loadValid  (serLoad),
    .loadWord   (serWord),
    .scrambleOn (scrambleOn),
    .loadReady  (loadReady),
    .serOutP_r  (currentModeSerialP),
    .serOutN_r  (currentModeSerialN)
  );
endmodule // spin_parallel_input

// [test/spin_par_asserts.sv]
// Port-level checks of the parallel input stage
`timescale 1ns/100ps
module spin_par_asserts (
  input wire        sys_clk,
  input wire        rst,
  input wire        clkEn,
  input wire        powerDownN,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        currentModeSerialP,
  input wire        currentModeSerialN,
  input wire        selfTestPass_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire req = avs_read | avs_write;

  a_wait_one_state: assert property (clkEn && req && !$past(req) |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_idle_high: assert property (!req |-> avs_waitrequest)
    else $error("waitrequest low at idle");
  a_rdata_held: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data moved between accesses");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
    else $error("unaligned read not zero");
  a_reset_idle: assert property (disable iff (1'b0) rst |-> avs_waitrequest && currentModeSerialP && currentModeSerialN && !selfTestPass_r)
    else $error("outputs not idle in reset");
  a_pdown_high: assert property (!powerDownN [*5] |-> currentModeSerialP && currentModeSerialN)
    else $error("serial pins not high in power-down");
  a_pdown_no_pass: assert property (!powerDownN [*5] |-> !selfTestPass_r)
    else $error("pass flag in power-down");
  a_diff_pair: assert property (powerDownN [*8] |-> currentModeSerialP != currentModeSerialN)
    else $error("serial pair not complementary");
endmodule // spin_par_asserts

bind spin_parallel_input spin_par_asserts u_spin_par_asserts (
  .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .powerDownN(powerDownN),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .currentModeSerialP(currentModeSerialP),
  .currentModeSerialN(currentModeSerialN),
  .selfTestPass_r(selfTestPass_r));

// [test/spin_video_src.sv]
// Behavioural video source driving the parallel pixel bus
`timescale 1ns/100ps
module spin_video_src (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        go,
  input  wire [7:0]  toggles,
  input  wire [23:0] rnd,
  output reg         pclk,
  output reg  [23:0] pixel,
  output reg         dv,
  output reg         ls,
  output reg         fs,
  output wire        busy
);
  reg [7:0] left;
  reg [1:0] div;
  reg [7:0] pcnt;
  assign busy = (left != 8'h0);
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {pclk, pixel, dv, ls, fs} <= 28'h0;
      left <= 8'h0;
      div <= 2'h0;
      pcnt <= 8'h0;
    end else if (go) begin
      left <= toggles;
      div <= 2'h0;
    end else if (busy) begin
      // Half period of three cycles, slow enough for two-stage sampling
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      if (div == 2'h1)
        pixel <= {rnd[23:16], rnd[15:8], rnd[7:0]}; // blue, green, red
      if (div == 2'h2) begin
        pclk <= ~pclk;
        left <= left - 8'h1;
        if (!pclk) begin
          pcnt <= (pcnt == 8'h81) ? 8'h0 : pcnt + 8'h1;
          if (pcnt == 8'h40 || pcnt == 8'h81) dv <= ~dv;
          if (pcnt == 8'h20 || pcnt == 8'h61) ls <= ~ls;
          if (pcnt == 8'h81) fs <= ~fs;
        end
      end
    end
  end
endmodule // spin_video_src

// [test/testbench.sv]
// Self-checking bench of the parallel pixel input stage
`timescale 1ns/100ps
`include "spin_consts.vh"
module testbench;
  reg         sys_clk = 1'b0;
  reg         rst = 1'b0;
  reg         powerDownN = 1'b1;
  reg         edgeSel = 1'b1;
  reg  [1:0]  cfgSel = 2'h0;
  reg         stEn = 1'b0;
  reg         breakLink = 1'b0;
  reg  [3:0]  avs_address = 4'h0;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [3:0]  avs_byteenable = 4'h0;
  reg         go = 1'b0;
  reg  [7:0]  tg = 8'h0;
  reg  [31:0] rnd = 32'h0;
  reg  [31:0] d, wc;
  reg         lvl = 1'b0;
  wire        pclk, dv, ls, fs, busy, serP, serN, pass, avs_waitrequest;
  wire [23:0] pixel;
  wire [31:0] avs_readdata;
  integer     seed = 82;
  integer     err_total = 0;
  integer     total_checks = 0;
  integer     i;

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rnd <= $random(seed);

  spin_video_src u_spin_video_src (.sys_clk(sys_clk), .rst(rst), .go(go),
    .toggles(tg), .rnd(rnd[23:0]), .pclk(pclk), .pixel(pixel), .dv(dv),
    .ls(ls), .fs(fs), .busy(busy));

  spin_parallel_input u_spin_parallel_input (.sys_clk(sys_clk), .rst(rst),
    .clkEn(1'b1), .parallelClockIn(pclk), .pixelWordIn(pixel),
    .dataValidCtrl(dv), .lineSyncCtrl(ls), .frameSyncCtrl(fs),
    .strobeEdgeSelect(edgeSel), .configSelect(cfgSel),
    .powerDownN(powerDownN), .selfTestEnable(stEn),
    .linkReturn(serP ^ breakLink), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .currentModeSerialP(serP), .currentModeSerialN(serN),
    .selfTestPass_r(pass));

  task stop_test;
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task acc(input wr, input [3:0] a, input [31:0] wd, input [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Captures of one burst: pclk toggles tg times from level l
  function [31:0] expCap(input l, input [7:0] t, input sel);
    reg [31:0] r;
    r = l ? t / 2 : (t + 1) / 2;
    expCap = sel ? r : t - r;
  endfunction

  initial begin
    // Raised after time zero so the async resets see an edge
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    acc(0, `SPIN_OFF_CTRL, 0, 0);
    chk(d, {26'h0, `SPIN_CTRL_RESET});
    acc(0, `SPIN_OFF_STATUS, 0, 0);
    chk(d, 32'h0);
    acc(0, 4'h2, 0, 0);
    chk(d, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      acc(1, `SPIN_OFF_CTRL, {27'h0, i[2:0], 2'h1}, 4'h1);
      acc(0, `SPIN_OFF_CTRL, 0, 0);
      chk(d, {27'h0, i[2:0], 2'h1});
    end
    acc(1, `SPIN_OFF_CTRL, 32'h3e, 4'h0);
    acc(0, `SPIN_OFF_CTRL, 0, 0);
    chk(d, 32'h1d);
    acc(1, `SPIN_OFF_CTRL, 32'h1, 4'h1);
    acc(0, `SPIN_OFF_WORDCNT, 0, 0);
    wc = d;
    for (i = 0; i < 6; i = i + 1) begin
      d = $random(seed);
      edgeSel <= i[0];
      cfgSel <= d[5:4];
      // Long last burst outruns the serializer
      tg <= (i == 5) ? 8'h0f : {4'h0, d[3:1], 1'b1};
      repeat (4) @(posedge sys_clk);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge sys_clk);
      while (busy)
        @(posedge sys_clk);
      repeat (8) @(posedge sys_clk);
      acc(0, `SPIN_OFF_WORDCNT, 0, 0);
      chk(d - wc, expCap(lvl, tg, i[0]));
      wc = d;
      lvl = lvl ^ tg[0];
    end
    acc(0, `SPIN_OFF_STATUS, 0, 0);
    chk(d & 32'h1, 32'h1);
    acc(1, `SPIN_OFF_STATUS, 32'h1, 4'h1);
    acc(0, `SPIN_OFF_STATUS, 0, 0);
    chk(d & 32'h1, 32'h0);
    stEn <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk({31'h0, pass}, 32'h1);
    breakLink <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk({31'h0, pass}, 32'h0);
    breakLink <= 1'b0;
    stEn <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({31'h0, pass}, 32'h0);
    // Register override of the self-test select
    acc(1, `SPIN_OFF_CTRL, 32'h23, 4'h1);
    repeat (20) @(posedge sys_clk);
    acc(0, `SPIN_OFF_STATUS, 0, 0);
    chk(d, 32'h6);
    acc(1, `SPIN_OFF_CTRL, 32'h1d, 4'h1);
    powerDownN <= 1'b0;
    repeat (8) @(posedge sys_clk);
    powerDownN <= 1'b1;
    repeat (4) @(posedge sys_clk);
    acc(0, `SPIN_OFF_CTRL, 0, 0);
    chk(d, {26'h0, `SPIN_CTRL_RESET});
    stop_test;
  end

  // Sequence needs under six hundred cycles; twenty thousand cycles is a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total = err_total + 1;
    stop_test;
  end
endmodule // testbench
